// *** logic/ucs_control_status.sv ***
// Functional notes
// - 8-bit filter: receive-done needs high stop bit
// - 9-bit filter: receive-done needs high ninth bit
// - Transmit-done set at stop bit start
// - Transmit-done requests interrupt when enabled
// - 9-bit frame: start, eight, ninth, stop
// - Receive only while receive enable set
// - Load data, ninth, flag only if flag clear
// - 9-bit receive stores ninth bit, ignores stop
`timescale 1ns/1ps
module ucs_control_status (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_bit_wr,
  input  wire logic [2:0] i_bit_idx,
  input  wire logic       i_bit_val,
  input  wire logic       i_port_int_en,
  input  wire logic       i_tick16,
  input  wire logic       i_rxd,
  output logic [7:0]      o_sfr_rdata,
  output logic            o_txd,
  output logic            o_port_irq
);
  // All state of the control block
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       rx_buf;
    logic [7:0]       tx_shift;
    logic [2:0]       tx_cnt;
    logic [3:0]       tx_tick;
    ucs_pkg::ucs_tx_e tx_st;
    logic             txd;
    logic             irq;
    logic [7:0]       rdata;
    logic [1:0]       rxd_sync;
  } ucs_ctl_s;

  ucs_ctl_s s_q;        // Registered state
  ucs_ctl_s s_d;        // Next state
  logic     rx_done;    // Frame received pulse
  logic [7:0] rx_data;  // Received byte
  logic     rx_ninth;   // Received ninth bit
  logic     rx_stop;    // Received stop bit

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Read view of the control register; unused bit reads one
  function automatic logic [7:0] ctrl_view(input logic [7:0] c);
    ctrl_view = c;
    ctrl_view[ucs_pkg::ONE_BIT] = 1'b1;
  endfunction

  // Address decode for the control register
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == ucs_pkg::CTRL_ADDR);
  endfunction

  // Address decode for the data buffer
  function automatic logic is_data(input logic [7:0] a);
    is_data = (a == ucs_pkg::DATA_ADDR);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Receiver shift engine
  // Fed from the synchronised pin; clearing the enable drops a frame
  ucs_rx_shifter i_ucs_rx_shifter (
    .i_sys_clk    (i_sys_clk),
    .i_sys_rst    (i_sys_rst),
    .i_tick16     (i_tick16),
    .i_rxd        (s_q.rxd_sync[1]),
    .i_enable     (s_q.ctrl[ucs_pkg::REN_BIT]),
    .i_ninth_mode (s_q.ctrl[ucs_pkg::FMT_BIT]),
    .o_done       (rx_done),
    .o_data       (rx_data),
    .o_ninth      (rx_ninth),
    .o_stop       (rx_stop)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register file, transmitter and flags
  always_comb begin
    logic mode9;        // Nine-bit frame format selected
    logic qual;         // Address filter passes the frame
    logic tx_set;       // Transmit-done set event
    logic ctl_byte_wr;  // Whole-byte write to control
    logic ctl_bit_wr;   // Single-bit write to control
    logic dat_wr;       // Byte write to the data buffer
    mode9       = s_q.ctrl[ucs_pkg::FMT_BIT];
    qual        = 1'b0;
    tx_set      = 1'b0;
    // Strobe decode; a byte write takes priority over a bit write
    ctl_byte_wr = i_sfr_wr && is_ctrl(i_sfr_addr);
    ctl_bit_wr  = i_bit_wr && is_ctrl(i_sfr_addr);
    dat_wr      = i_sfr_wr && is_data(i_sfr_addr);
    s_d         = s_q;
    // Pin synchroniser; only the second stage feeds the receiver,
    // the first may still be settling from a metastable sample
    s_d.rxd_sync = {s_q.rxd_sync[0], i_rxd};

    // Software writes, whole byte or single bit
    if (ctl_byte_wr) begin
      s_d.ctrl = i_sfr_wdata;
    end else if (ctl_bit_wr) begin
      s_d.ctrl[i_bit_idx] = i_bit_val;
    end
    // Spare bit is never stored; the read view supplies its one
    s_d.ctrl[ucs_pkg::ONE_BIT] = 1'b0;

    // Transmit sequencer, sixteen ticks per bit
    // A data write while busy would corrupt the frame on the line,
    // so it is dropped, also during the stop bit after transmit-done is set
    unique case (s_q.tx_st)
      ucs_pkg::TX_IDLE: begin
        // Data write starts a frame; writes while busy are dropped
        if (dat_wr) begin
          s_d.tx_shift = i_sfr_wdata;
          s_d.tx_st    = ucs_pkg::TX_START;
          s_d.tx_tick  = 4'h0;
          s_d.txd      = 1'b0;
        end
      end
      default: begin
        if (i_tick16) begin
          s_d.tx_tick = s_q.tx_tick + 4'h1;
          if (s_q.tx_tick == ucs_pkg::TICK_LAST) begin
            unique case (s_q.tx_st)
              ucs_pkg::TX_START: begin
                // First data bit, least significant first
                s_d.tx_st  = ucs_pkg::TX_DATA;
                s_d.tx_cnt = 3'h0;
                s_d.txd    = s_q.tx_shift[0];
              end
              ucs_pkg::TX_DATA: begin
                s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
                s_d.tx_cnt   = s_q.tx_cnt + 3'h1;
                if (s_q.tx_cnt != ucs_pkg::DATA_LAST) begin
                  s_d.txd = s_q.tx_shift[1];
                end else if (mode9) begin
                  // Programmable ninth bit
                  s_d.tx_st = ucs_pkg::TX_NINTH;
                  s_d.txd   = s_q.ctrl[ucs_pkg::TB8_BIT];
                end else begin
                  // Eighth bit done: stop bit begins
                  s_d.tx_st = ucs_pkg::TX_STOP;
                  s_d.txd   = 1'b1;
                  tx_set    = 1'b1;
                end
              end
              ucs_pkg::TX_NINTH: begin
                // Stop bit begins
                s_d.tx_st = ucs_pkg::TX_STOP;
                s_d.txd   = 1'b1;
                tx_set    = 1'b1;
              end
              ucs_pkg::TX_STOP: begin
                // Stop bit over, line stays high
                s_d.tx_st = ucs_pkg::TX_IDLE;
              end
              default:          s_d.tx_st = ucs_pkg::TX_IDLE;
            endcase
          end
        end
      end
    endcase
    // Hardware set wins over a same-cycle software clear
    if (tx_set) begin
      s_d.ctrl[ucs_pkg::TID_BIT] = 1'b1;
    end

    // Receive qualification: a frame that fails the filter, or that
    // arrives while the previous one is unread, changes nothing, so
    // software never loses a byte it has not yet fetched
    if (mode9) begin
      qual = !s_q.ctrl[ucs_pkg::AFE_BIT] || rx_ninth;
    end else begin
      qual = !s_q.ctrl[ucs_pkg::AFE_BIT] || rx_stop;
    end
    if (rx_done && !s_q.ctrl[ucs_pkg::RID_BIT] && qual) begin
      s_d.rx_buf = rx_data;
      // Ninth bit in 9-bit mode, stop bit in 8-bit mode
      s_d.ctrl[ucs_pkg::RB8_BIT] = mode9 ? rx_ninth : rx_stop;
      s_d.ctrl[ucs_pkg::RID_BIT] = 1'b1;
    end

    // Level interrupt request from either flag; built from the next
    // flag values so the request rises on the edge that sets a flag
    s_d.irq = i_port_int_en &&
              (s_d.ctrl[ucs_pkg::TID_BIT] ||
               s_d.ctrl[ucs_pkg::RID_BIT]);

    // Registered read data; unmapped addresses read zero
    // Data reads return the receive latch, never the transmit shifter
    if (is_ctrl(i_sfr_addr)) begin
      s_d.rdata = ctrl_view(s_q.ctrl);
    end else if (is_data(i_sfr_addr)) begin
      s_d.rdata = s_q.rx_buf;
    end else begin
      s_d.rdata = 8'h00;
    end
  end

  // State register
  // Reset leaves the line idle high and the synchroniser at the
  // idle level of the pin, so no false start bit follows reset
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q          <= '0;
      s_q.ctrl     <= ucs_pkg::CTRL_RESET & 8'hBF;
      s_q.rx_buf   <= ucs_pkg::DATA_RESET;
      s_q.tx_st    <= ucs_pkg::TX_IDLE;
      s_q.txd      <= 1'b1;
      s_q.rxd_sync <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_sfr_rdata = s_q.rdata;
  assign o_txd       = s_q.txd;
  assign o_port_irq  = s_q.irq;
endmodule

// *** logic/ucs_pkg.sv ***
package ucs_pkg;
  // Special function register addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h98;
  localparam logic [7:0] DATA_ADDR  = 8'h99;
  // Control register field positions
  localparam int unsigned FMT_BIT   = 7;
  localparam int unsigned ONE_BIT   = 6;
  localparam int unsigned AFE_BIT   = 5;
  localparam int unsigned REN_BIT   = 4;
  localparam int unsigned TB8_BIT   = 3;
  localparam int unsigned RB8_BIT   = 2;
  localparam int unsigned TID_BIT   = 1;
  localparam int unsigned RID_BIT   = 0;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Oversampling: sixteen ticks per bit, mid sample after eight
  localparam logic [3:0] TICK_LAST  = 4'hF;
  localparam logic [3:0] TICK_MID   = 4'h7;
  localparam logic [2:0] DATA_LAST  = 3'h7;
  // Transmit and receive sequencer states
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP
  } ucs_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
  } ucs_rx_e;
endpackage

// *** logic/ucs_rx_shifter.sv ***
`timescale 1ns/1ps
module ucs_rx_shifter (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_tick16,
  input  wire logic       i_rxd,
  input  wire logic       i_enable,
  input  wire logic       i_ninth_mode,
  output logic            o_done,
  output logic [7:0]      o_data,
  output logic            o_ninth,
  output logic            o_stop
);
  // All receiver state
  typedef struct packed {
    ucs_pkg::ucs_rx_e st;
    logic [3:0]       tick;
    logic [2:0]       cnt;
    logic [7:0]       data;
    logic             ninth;
    logic             stop;
    logic             done;
  } ucs_rx_s;

  ucs_rx_s r_q;  // Registered state
  ucs_rx_s r_d;  // Next state

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    if (!i_enable) begin
      // Disabled: drop any frame in progress
      r_d.st = ucs_pkg::RX_IDLE;
    end else if (i_tick16) begin
      r_d.tick = r_q.tick + 4'h1;
      unique case (r_q.st)
        ucs_pkg::RX_IDLE: begin
          // Falling edge starts a frame
          if (!i_rxd) begin
            r_d.st   = ucs_pkg::RX_START;
            r_d.tick = 4'h0;
          end
        end
        ucs_pkg::RX_START: begin
          // Recheck start bit at mid point
          if (r_q.tick == ucs_pkg::TICK_MID) begin
            r_d.tick = 4'h0;
            r_d.cnt  = 3'h0;
            r_d.st   = i_rxd ? ucs_pkg::RX_IDLE : ucs_pkg::RX_DATA;
          end
        end
        ucs_pkg::RX_DATA: begin
          // Shift in least significant bit first
          if (r_q.tick == ucs_pkg::TICK_LAST) begin
            r_d.data = {i_rxd, r_q.data[7:1]};
            r_d.cnt  = r_q.cnt + 3'h1;
            if (r_q.cnt == ucs_pkg::DATA_LAST) begin
              r_d.st = i_ninth_mode ? ucs_pkg::RX_NINTH : ucs_pkg::RX_STOP;
            end
          end
        end
        ucs_pkg::RX_NINTH: begin
          // Capture the ninth data bit
          if (r_q.tick == ucs_pkg::TICK_LAST) begin
            r_d.ninth = i_rxd;
            r_d.st    = ucs_pkg::RX_STOP;
          end
        end
        ucs_pkg::RX_STOP: begin
          // Sample stop bit and report the frame
          if (r_q.tick == ucs_pkg::TICK_LAST) begin
            r_d.stop = i_rxd;
            r_d.done = 1'b1;
            r_d.st   = ucs_pkg::RX_IDLE;
          end
        end
        default: r_d.st = ucs_pkg::RX_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_done  = r_q.done;
  assign o_data  = r_q.data;
  assign o_ninth = r_q.ninth;
  assign o_stop  = r_q.stop;
endmodule

// *** bench/ucs_control_status_sva.sv ***
`timescale 1ns/1ps
module ucs_control_status_sva (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_bit_wr,
  input wire logic [2:0] i_bit_idx,
  input wire logic       i_bit_val,
  input wire logic       i_port_int_en,
  input wire logic       i_tick16,
  input wire logic       i_rxd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_txd,
  input wire logic       o_port_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // Control register on the read port, no writes
  sequence ctl_rd;
    i_sfr_addr == ucs_pkg::CTRL_ADDR && !i_sfr_wr && !i_bit_wr;
  endsequence
  // Start bit spans at least eight clocks
  sequence start_low;
    !o_txd [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_IRQ_CAUSE: assert property (
    $rose(o_port_irq) |-> $past(i_port_int_en))
    else $error("irq rose while disabled");
  AST_IRQ_MASK: assert property (
    !i_port_int_en |=> !o_port_irq)
    else $error("irq while masked");
  AST_FLAG_HOLD: assert property (
    (!i_sfr_wr && !i_bit_wr) [*2] ##0 (o_port_irq && i_port_int_en)
    |=> o_port_irq)
    else $error("flag dropped without write");
  AST_START_LEN: assert property (
    $fell(o_txd) |-> start_low)
    else $error("start bit too short");
  AST_TXD_PACE: assert property (
    $changed(o_txd) |-> $past(i_tick16) || $past(i_sfr_wr))
    else $error("txd moved off tick");
  AST_RX_GATED: assert property (
    ctl_rd ##1 (ctl_rd and (!o_sfr_rdata[4] && !o_sfr_rdata[0]))
    ##1 ctl_rd
    |=> !o_sfr_rdata[0])
    else $error("frame taken while disabled");
  AST_NINTH_HOLD: assert property (
    ctl_rd ##1 (ctl_rd and o_sfr_rdata[0]) |=> $stable(o_sfr_rdata[2]))
    else $error("ninth bit loaded over full flag");
  AST_TX_DONE_STOP: assert property (
    ctl_rd ##1 (ctl_rd and !o_sfr_rdata[1]) ##1 o_sfr_rdata[1]
    |-> $past(o_txd))
    else $error("tx done before stop");
endmodule

// *** bench/ucs_remote_uart.sv ***
`timescale 1ns/1ps
module ucs_remote_uart (
  input  wire logic i_sys_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  // Line idles high between frames
  initial o_rxd = 1'b1;
  // One frame, LSB first, 32 clocks a bit
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      @(posedge i_sys_clk);
      #1 o_rxd = f[i];
      repeat (31) @(posedge i_sys_clk);
    end
    #1;
  endtask
  // Bounded wait for start, then sample mid bit
  task automatic recv(input int n, output logic [10:0] f, output logic ok);
    f = '1;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge i_sys_clk);
      ok = !i_txd;
    end
    repeat (16) @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = i_txd;
      repeat (32) @(posedge i_sys_clk);
    end
    #1;
  endtask
endmodule

// *** bench/uart_control_status_logic_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module uart_control_status_logic_bench;
  logic       i_sys_clk, i_sys_rst, i_sfr_wr, i_bit_wr, i_bit_val;
  logic       i_port_int_en, i_tick16, i_rxd, o_txd, o_port_irq;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
  logic [2:0] i_bit_idx;
  int         error_cnt, cmp_count;
  ucs_control_status i_ucs_control_status (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_bit_wr(i_bit_wr), .i_bit_idx(i_bit_idx),
    .i_bit_val(i_bit_val), .i_port_int_en(i_port_int_en),
    .i_tick16(i_tick16), .i_rxd(i_rxd), .o_sfr_rdata(o_sfr_rdata),
    .o_txd(o_txd), .o_port_irq(o_port_irq));
  ucs_remote_uart i_ucs_remote_uart (.i_sys_clk(i_sys_clk), .i_txd(o_txd),
    .o_rxd(i_rxd));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Tick every other clock: 32 clocks a bit
  initial begin
    i_tick16 = 1'b0;
    forever @(posedge i_sys_clk) #1 i_tick16 = ~i_tick16;
  end
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    step();
    i_sfr_wr = 1'b0;
    i_sfr_addr = ucs_pkg::CTRL_ADDR;
    // Let an edge pass so a following call never retoggles the strobe
    step();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_sfr_addr = a;
    step();
    d = o_sfr_rdata;
    i_sfr_addr = ucs_pkg::CTRL_ADDR;
    // Let an edge pass before the address may move again
    step();
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Send a frame, then judge flag, ninth bit and buffer
  task automatic rx(input logic [10:0] f, input logic rid,
                    input logic [7:0] dat, input logic rb8);
    logic [7:0] c, d;
    i_ucs_remote_uart.send(f);
    repeat (8) step();
    rd(ucs_pkg::CTRL_ADDR, c);
    rd(ucs_pkg::DATA_ADDR, d);
    `CHK("rx state", {rb8, rid, dat}, {c[2], c[0], d})
  endtask
  task automatic t_reset();
    logic [7:0] c, d;
    rd(ucs_pkg::CTRL_ADDR, c);
    rd(ucs_pkg::DATA_ADDR, d);
    `CHK("reset regs", 16'h4000, {c, d})
  endtask
  task automatic t_tx(input logic fmt);
    logic [10:0] f;
    logic [7:0]  c;
    logic        ok;
    wr(ucs_pkg::CTRL_ADDR, {fmt, 7'h08});
    i_port_int_en = 1'b1;
    wr(ucs_pkg::DATA_ADDR, 8'hA5);
    i_ucs_remote_uart.recv(fmt ? 11 : 10, f, ok);
    `CHK("tx start", 1'b1, ok)
    if (!ok) finish_test();
    `CHK("tx frame", 11'h74A, f)
    rd(ucs_pkg::CTRL_ADDR, c);
    `CHK("tx done", 2'b11, {c[1], o_port_irq})
    i_bit_idx = 3'h1;
    i_bit_val = 1'b0;
    i_bit_wr = 1'b1;
    step();
    i_bit_wr = 1'b0;
    step();
    `CHK("irq clear", 1'b0, o_port_irq)
  endtask
  task automatic t_rx9();
    wr(ucs_pkg::CTRL_ADDR, 8'hB0);
    rx({2'b10, 8'h3C, 1'b0}, 1'b0, 8'h00, 1'b0);
    rx({2'b11, 8'h3C, 1'b0}, 1'b1, 8'h3C, 1'b1);
    `CHK("rx irq", 1'b1, o_port_irq)
    // Masking drops the request while the flag stays set
    i_port_int_en = 1'b0;
    step();
    `CHK("irq masked", 1'b0, o_port_irq)
    i_port_int_en = 1'b1;
    rx({2'b11, 8'h55, 1'b0}, 1'b1, 8'h3C, 1'b1);
    // Filter off: ninth bit low is still taken
    wr(ucs_pkg::CTRL_ADDR, 8'h90);
    rx({2'b10, 8'hC3, 1'b0}, 1'b1, 8'hC3, 1'b0);
  endtask
  task automatic t_rx8();
    wr(ucs_pkg::CTRL_ADDR, 8'h30);
    rx({2'b10, 8'h96, 1'b0}, 1'b0, 8'hC3, 1'b0);
    rx({2'b11, 8'h96, 1'b0}, 1'b1, 8'h96, 1'b1);
    wr(ucs_pkg::CTRL_ADDR, 8'h10);
    rx({2'b10, 8'h69, 1'b0}, 1'b1, 8'h69, 1'b0);
  endtask
  task automatic t_ren();
    wr(ucs_pkg::CTRL_ADDR, 8'hA0);
    rx({2'b11, 8'h5A, 1'b0}, 1'b0, 8'h69, 1'b0);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    i_sfr_addr = ucs_pkg::CTRL_ADDR;
    i_sfr_wdata = 8'h00;
    i_sfr_wr = 1'b0;
    i_bit_wr = 1'b0;
    i_bit_idx = 3'h0;
    i_bit_val = 1'b0;
    i_port_int_en = 1'b0;
    repeat (8) step();
    i_sys_rst = 1'b0;
    t_reset();
    t_tx(1'b1);
    t_tx(1'b0);
    t_rx9();
    t_rx8();
    t_ren();
    finish_test();
  end
endmodule
bind ucs_control_status ucs_control_status_sva i_ucs_control_status_sva (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_bit_wr(i_bit_wr),
  .i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val),
  .i_port_int_en(i_port_int_en), .i_tick16(i_tick16), .i_rxd(i_rxd),
  .o_sfr_rdata(o_sfr_rdata), .o_txd(o_txd), .o_port_irq(o_port_irq));
